//--- hw/tdte_engine.sv
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "tdte_defs.svh"
`default_nettype none

module tdte_engine
#(
	parameter int N_SRC = 8
)
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [N_SRC-1:0] irq_req,
	input wire logic [N_SRC-1:0][2:0] irq_level,
	input wire logic hp_pending,
	input wire logic [23:0] vector_base,
	output logic [N_SRC-1:0] cpu_irq_req,
	output logic [N_SRC-1:0] req_ack,
	output logic eot_irq,
	output logic [31:0] eot_jump_addr,
	output logic busy,
	output var tdte_pkg::tdte_mem_req_t mem_req,
	input wire logic [7:0] mem_rdata
);

	logic [7:0] exit_pri_reg;
	logic [7:0] rdata_reg;
	logic [N_SRC-1:0] cpu_irq_reg;
	logic [N_SRC-1:0] ack_reg;
	logic eot_reg;
	logic [31:0] eot_addr_reg;
	logic busy_reg;
	tdte_pkg::tdte_mem_req_t mem_reg;
	tdte_pkg::tdte_state_t state_reg;
	tdte_pkg::tdte_state_t ret_reg;
	logic [1:0] phase_reg;
	logic [23:0] ptr_reg;
	logic [3:0] nbytes_reg;
	logic [2:0] bidx_reg;
	logic we_reg;
	logic [63:0] wval_reg;
	logic [63:0] acc_reg;
	logic [23:0] tbl_reg;
	logic [23:0] vec_reg;
	logic [15:0] mode_reg;
	logic [15:0] count_reg;
	logic [15:0] src_reg;
	logic [15:0] op_reg;
	logic [15:0] dst_reg;
	logic [15:0] opnd_reg;
	logic [2:0] midx_reg;

	logic engine_on;
	logic [N_SRC-1:0] dma_sel;
	logic [N_SRC-1:0] dma_req;
	logic [N_SRC-1:0] pick_onehot;
	logic [23:0] pick_vec;
	logic word;
	logic multi;
	logic imm;
	logic arith;
	logic [15:0] step;
	logic [3:0] nb;
	logic [15:0] sum;
	logic [23:0] ptr_base;
	logic [2:0] mcount;

	assign engine_on = exit_pri_reg[`TDTE_SEL_BIT];
	assign word = mode_reg[`TDTE_MODE_WORD];
	assign multi = mode_reg[`TDTE_MODE_MULTI];
	// Multiple mode is memory-to-memory only, so immediate and sum are forced off there.
	assign imm = mode_reg[`TDTE_MODE_IMM] & ~multi;
	assign arith = mode_reg[`TDTE_MODE_ARITH] & ~multi;
	assign step = word ? 16'h0002 : 16'h0001;
	assign nb = word ? 4'h2 : 4'h1;
	assign mcount = mode_reg[`TDTE_MCNT_LSB +: 3];
	assign ptr_base = tbl_reg + (arith ? `TDTE_OFS_PTR_ARITH : `TDTE_OFS_PTR_PLAIN);
	assign sum = word ? (opnd_reg + acc_reg[15:0]) : {8'h00, opnd_reg[7:0] + acc_reg[7:0]};

	always_comb
	begin
		for (int i = 0; i < N_SRC; i++)
		begin
			dma_sel[i] = engine_on && (irq_level[i] == `TDTE_DMA_LEVEL);
		end
		dma_req = irq_req & dma_sel;
		pick_onehot = '0;
		pick_vec = vector_base;
		for (int i = N_SRC - 1; i >= 0; i--)
		begin
			if (dma_req[i])
			begin
				pick_onehot = '0;
				pick_onehot[i] = 1'b1;
				pick_vec = vector_base + 24'(i * 4);
			end
		end
	end

	// Register port.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			exit_pri_reg <= `TDTE_EXIT_PRI_RST;
		end
		else if (reg_wr && reg_addr == `TDTE_REG_EXIT_PRI)
		begin
			exit_pri_reg <= reg_wdata;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			rdata_reg <= 8'h00;
		end
		else if (reg_rd && reg_addr == `TDTE_REG_EXIT_PRI)
		begin
			rdata_reg <= exit_pri_reg;
		end
		else if (reg_rd && reg_addr == `TDTE_REG_STATUS)
		begin
			rdata_reg <= {7'h00, busy_reg};
		end
		else
		begin
			rdata_reg <= 8'h00;
		end
	end

	// Level-7 requests are withheld from the CPU while the engine is selected.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			cpu_irq_reg <= '0;
		end
		else
		begin
			cpu_irq_reg <= irq_req & ~dma_sel;
		end
	end

	task automatic start_mem(input logic [23:0] p, input logic [3:0] n, input logic we,
		input logic [63:0] wv, input tdte_pkg::tdte_state_t r);
		ptr_reg <= p;
		nbytes_reg <= n;
		bidx_reg <= 3'h0;
		we_reg <= we;
		wval_reg <= wv;
		phase_reg <= 2'h0;
		ret_reg <= r;
		state_reg <= tdte_pkg::S_MEM;
	endtask

	// Sequencer: every table, operand and pointer access goes byte by byte through S_MEM.
	// Byte accesses cost bandwidth but let a word at 0FFFF spill naturally into 10000.
	always_ff @(posedge mclk)
	begin
		if (reset)
		begin
			state_reg <= tdte_pkg::S_IDLE;
			ret_reg <= tdte_pkg::S_IDLE;
			phase_reg <= 2'h0;
			ptr_reg <= 24'h000000;
			nbytes_reg <= 4'h0;
			bidx_reg <= 3'h0;
			we_reg <= 1'b0;
			wval_reg <= 64'h0;
			acc_reg <= 64'h0;
			tbl_reg <= 24'h000000;
			vec_reg <= 24'h000000;
			mode_reg <= 16'h0000;
			count_reg <= 16'h0000;
			src_reg <= 16'h0000;
			op_reg <= 16'h0000;
			dst_reg <= 16'h0000;
			opnd_reg <= 16'h0000;
			midx_reg <= 3'h0;
			mem_reg <= '0;
			ack_reg <= '0;
			eot_reg <= 1'b0;
			eot_addr_reg <= 32'h00000000;
			busy_reg <= 1'b0;
		end
		else
		begin
			ack_reg <= '0;
			eot_reg <= 1'b0;
			busy_reg <= (state_reg != tdte_pkg::S_IDLE);
			case (state_reg)
				tdte_pkg::S_IDLE:
				begin
					// The CPU enable flag and level are deliberately not inputs here.
					if (|dma_req && !hp_pending)
					begin
						ack_reg <= pick_onehot;
						vec_reg <= pick_vec;
						start_mem(pick_vec, 4'h4, 1'b0, 64'h0, tdte_pkg::S_TBL);
					end
				end
				tdte_pkg::S_MEM:
				begin
					if (we_reg)
					begin
						if (phase_reg == 2'h0)
						begin
							mem_reg.addr <= ptr_reg + 24'(bidx_reg);
							mem_reg.wr <= 1'b1;
							mem_reg.wdata <= wval_reg[bidx_reg*8 +: 8];
							phase_reg <= 2'h1;
						end
						else
						begin
							mem_reg.wr <= 1'b0;
							bidx_reg <= bidx_reg + 3'h1;
							phase_reg <= 2'h0;
							if ({1'b0, bidx_reg} + 4'h1 == nbytes_reg)
							begin
								state_reg <= ret_reg;
							end
						end
					end
					else
					begin
						if (phase_reg == 2'h0)
						begin
							mem_reg.addr <= ptr_reg + 24'(bidx_reg);
							mem_reg.rd <= 1'b1;
							phase_reg <= 2'h1;
						end
						else if (phase_reg == 2'h1)
						begin
							mem_reg.rd <= 1'b0;
							phase_reg <= 2'h2;
						end
						else
						begin
							acc_reg[bidx_reg*8 +: 8] <= mem_rdata;
							bidx_reg <= bidx_reg + 3'h1;
							phase_reg <= 2'h0;
							if ({1'b0, bidx_reg} + 4'h1 == nbytes_reg)
							begin
								state_reg <= ret_reg;
							end
						end
					end
				end
				tdte_pkg::S_TBL:
				begin
					tbl_reg <= acc_reg[23:0];
					start_mem(acc_reg[23:0], 4'h4, 1'b0, 64'h0, tdte_pkg::S_HDR);
				end
				tdte_pkg::S_HDR:
				begin
					mode_reg <= acc_reg[15:0];
					count_reg <= acc_reg[31:16];
					midx_reg <= 3'h0;
					if (acc_reg[`TDTE_MODE_MULTI])
					begin
						start_mem(tbl_reg + `TDTE_OFS_FIELDS, 4'h4, 1'b0, 64'h0, tdte_pkg::S_PAIR);
					end
					else
					begin
						start_mem(tbl_reg + `TDTE_OFS_FIELDS, acc_reg[`TDTE_MODE_ARITH] ? 4'h6 : 4'h4, 1'b0, 64'h0,
							tdte_pkg::S_CHK);
					end
				end
				tdte_pkg::S_CHK:
				begin
					src_reg <= acc_reg[15:0];
					if (arith)
					begin
						op_reg <= acc_reg[31:16];
						dst_reg <= acc_reg[47:32];
					end
					else
					begin
						dst_reg <= acc_reg[31:16];
					end
					if (count_reg == 16'h0000)
					begin
						state_reg <= tdte_pkg::S_IDLE;
					end
					else
					begin
						state_reg <= tdte_pkg::S_UNIT;
					end
				end
				tdte_pkg::S_PAIR:
				begin
					src_reg <= acc_reg[15:0];
					dst_reg <= acc_reg[31:16];
					state_reg <= tdte_pkg::S_UNIT;
				end
				tdte_pkg::S_UNIT:
				begin
					if (imm)
					begin
						opnd_reg <= word ? src_reg : {8'h00, src_reg[7:0]};
						state_reg <= tdte_pkg::S_OPND;
					end
					else
					begin
						start_mem({8'h00, src_reg}, nb, 1'b0, 64'h0, tdte_pkg::S_GOTSRC);
					end
				end
				tdte_pkg::S_GOTSRC:
				begin
					opnd_reg <= word ? acc_reg[15:0] : {8'h00, acc_reg[7:0]};
					state_reg <= tdte_pkg::S_OPND;
				end
				tdte_pkg::S_OPND:
				begin
					if (arith)
					begin
						start_mem({8'h00, op_reg}, nb, 1'b0, 64'h0, tdte_pkg::S_SUM);
					end
					else
					begin
						start_mem({8'h00, dst_reg}, nb, 1'b1, {48'h0, opnd_reg}, tdte_pkg::S_ADV);
					end
				end
				tdte_pkg::S_SUM:
				begin
					start_mem({8'h00, dst_reg}, nb, 1'b1, {48'h0, sum}, tdte_pkg::S_ADV);
				end
				tdte_pkg::S_ADV:
				begin
					// 16-bit adds wrap past 0FFFF to zero by themselves.
					if (mode_reg[`TDTE_MODE_SVAR] && !imm)
					begin
						src_reg <= src_reg + step;
					end
					if (mode_reg[`TDTE_MODE_SVAR] && !imm && arith)
					begin
						op_reg <= op_reg + step;
					end
					if (mode_reg[`TDTE_MODE_DVAR])
					begin
						dst_reg <= dst_reg + step;
					end
					if (multi)
					begin
						midx_reg <= midx_reg + 3'h1;
						if (midx_reg + 3'h1 == mcount)
						begin
							state_reg <= tdte_pkg::S_IDLE;
						end
						else
						begin
							start_mem(tbl_reg + `TDTE_OFS_FIELDS + {19'h0, midx_reg + 3'h1, 2'b00}, 4'h4, 1'b0, 64'h0,
								tdte_pkg::S_PAIR);
						end
					end
					else
					begin
						count_reg <= count_reg - 16'h0001;
						if (mode_reg[`TDTE_MODE_BURST] && count_reg != 16'h0001)
						begin
							state_reg <= tdte_pkg::S_UNIT;
						end
						else
						begin
							state_reg <= tdte_pkg::S_WB;
						end
					end
				end
				tdte_pkg::S_WB:
				begin
					// The table keeps the progress so the next request resumes from it.
					if (arith)
					begin
						start_mem(tbl_reg + `TDTE_OFS_COUNT, 4'h8, 1'b1, {dst_reg, op_reg, src_reg, count_reg},
							tdte_pkg::S_END);
					end
					else
					begin
						start_mem(tbl_reg + `TDTE_OFS_COUNT, 4'h6, 1'b1, {16'h0000, dst_reg, src_reg, count_reg},
							tdte_pkg::S_END);
					end
				end
				tdte_pkg::S_END:
				begin
					if (count_reg == 16'h0000 && mode_reg[`TDTE_MODE_CHAIN])
					begin
						start_mem(ptr_base, 4'h4, 1'b0, 64'h0, tdte_pkg::S_CHAINW);
					end
					else
					begin
						state_reg <= tdte_pkg::S_EOTCHK;
					end
				end
				tdte_pkg::S_CHAINW:
				begin
					start_mem(vec_reg, 4'h4, 1'b1, {32'h0, acc_reg[31:0]}, tdte_pkg::S_EOTCHK);
				end
				tdte_pkg::S_EOTCHK:
				begin
					if (count_reg == 16'h0000 && mode_reg[`TDTE_MODE_EOT])
					begin
						start_mem(ptr_base + (mode_reg[`TDTE_MODE_CHAIN] ? `TDTE_PTR_BYTES : 24'h000000), 4'h4, 1'b0,
							64'h0, tdte_pkg::S_EOTFIRE);
					end
					else
					begin
						state_reg <= tdte_pkg::S_IDLE;
					end
				end
				tdte_pkg::S_EOTFIRE:
				begin
					eot_reg <= 1'b1;
					eot_addr_reg <= acc_reg[31:0];
					state_reg <= tdte_pkg::S_IDLE;
				end
				default:
				begin
					state_reg <= tdte_pkg::S_IDLE;
				end
			endcase
		end
	end

	assign reg_rdata = rdata_reg;
	assign cpu_irq_req = cpu_irq_reg;
	assign req_ack = ack_reg;
	assign eot_irq = eot_reg;
	assign eot_jump_addr = eot_addr_reg;
	assign busy = busy_reg;
	assign mem_req = mem_reg;

endmodule

`default_nettype wire

//--- hw/tdte_defs.svh
`ifndef TDTE_DEFS_SVH
`define TDTE_DEFS_SVH

// Register port addresses and reset values.
`define TDTE_REG_EXIT_PRI 8'h9F
`define TDTE_REG_STATUS 8'hA0
`define TDTE_EXIT_PRI_RST 8'h00
`define TDTE_SEL_BIT 5

// Interrupt priority level that routes a request to the engine.
`define TDTE_DMA_LEVEL 3'h7

// Mode word bit positions.
`define TDTE_MODE_WORD 0
`define TDTE_MODE_IMM 1
`define TDTE_MODE_SVAR 2
`define TDTE_MODE_DVAR 3
`define TDTE_MODE_BURST 5
`define TDTE_MODE_EOT 6
`define TDTE_MODE_CHAIN 7
`define TDTE_MODE_ARITH 8
`define TDTE_MODE_MULTI 15
`define TDTE_MCNT_LSB 4

// Parameter table byte offsets.
`define TDTE_OFS_COUNT 24'h000002
`define TDTE_OFS_FIELDS 24'h000004
`define TDTE_OFS_PTR_PLAIN 24'h000008
`define TDTE_OFS_PTR_ARITH 24'h00000A
`define TDTE_PTR_BYTES 24'h000004

`endif

//--- hw/tdte_pkg.sv
package tdte_pkg;

	typedef struct packed {
		logic [23:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} tdte_mem_req_t;

	typedef enum logic [4:0] {
		S_IDLE,
		S_MEM,
		S_TBL,
		S_HDR,
		S_CHK,
		S_PAIR,
		S_UNIT,
		S_GOTSRC,
		S_OPND,
		S_SUM,
		S_ADV,
		S_WB,
		S_END,
		S_CHAINW,
		S_EOTCHK,
		S_EOTFIRE
	} tdte_state_t;

endpackage

//--- sim/tdte_mem_model.sv
`timescale 1ns/1ps
`default_nettype none

module tdte_mem_model
(
	input wire logic mclk,
	input wire tdte_pkg::tdte_mem_req_t mem_req,
	output logic [7:0] mem_rdata
);
	// Vector entries live here too, so chaining can rewrite them.
	logic [7:0] mem [0:131071];
	logic [7:0] q_reg = 8'hA5;

	assign mem_rdata = q_reg;

	// Outside the one valid cycle the data toggle, so a late sample shows up.
	always @(posedge mclk)
	begin
		if (mem_req.wr)
			mem[mem_req.addr[16:0]] <= mem_req.wdata;
		q_reg <= mem_req.rd ? mem[mem_req.addr[16:0]] : ~q_reg;
	end
endmodule

`default_nettype wire

//--- sim/tdte_engine_checker.sv
`timescale 1ns/1ps
`default_nettype none

module tdte_engine_checker
#(
	parameter int N_SRC = 8
)
(
	input wire logic mclk,
	input wire logic reset,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [N_SRC-1:0] irq_req,
	input wire logic [N_SRC-1:0][2:0] irq_level,
	input wire logic hp_pending,
	input wire logic [N_SRC-1:0] cpu_irq_req,
	input wire logic [N_SRC-1:0] req_ack,
	input wire logic eot_irq,
	input wire tdte_pkg::tdte_mem_req_t mem_req
);
	logic sel_reg;
	logic [N_SRC-1:0] cand;

	always_ff @(posedge mclk)
	begin
		if (reset)
			sel_reg <= 1'b0;
		else if (reg_wr && reg_addr == 8'h9F)
			sel_reg <= reg_wdata[5];
	end

	always_comb
	begin
		for (int i = 0; i < N_SRC; i++)
			cand[i] = irq_req[i] && irq_level[i] == 3'h7 && sel_reg;
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (reset);

	a_cpu_mask: assert property (cpu_irq_req == $past(irq_req & ~cand))
		else $error("cpu request not masked by engine routing");
	a_ack_cause: assert property (|req_ack |-> $onehot(req_ack) && |($past(cand) & req_ack))
		else $error("ack without an enabled level 7 request");
	a_ack_lowest: assert property (|req_ack |-> ($past(cand) & (req_ack - 1'b1)) == '0)
		else $error("ack not given to lowest pending source");
	a_hp_first: assert property (|req_ack |-> !$past(hp_pending))
		else $error("engine started while higher interrupt pending");
	a_ack_pulse: assert property (|req_ack |=> !(|req_ack))
		else $error("ack longer than one cycle");
	a_sel_read: assert property ($past(reg_rd) && $past(reg_addr) == 8'h9F |-> reg_rdata[5] == $past(sel_reg))
		else $error("select bit readback wrong");
	a_eot_pulse: assert property (eot_irq |=> !eot_irq)
		else $error("end interrupt longer than one cycle");
	a_unit_space: assert property (mem_req.rd || mem_req.wr |-> mem_req.addr <= 24'h010000 && !(mem_req.rd && mem_req.wr))
		else $error("memory access outside unit space");
endmodule

bind tdte_engine tdte_engine_checker #(.N_SRC(N_SRC)) chk_i (
	.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req), .irq_level(irq_level),
	.hp_pending(hp_pending), .cpu_irq_req(cpu_irq_req), .req_ack(req_ack), .eot_irq(eot_irq),
	.mem_req(mem_req));

`default_nettype wire

//--- sim/tdte_engine_bench.sv
`timescale 1ns/1ps
`default_nettype none

module tdte_engine_bench;
	localparam int NS = 4;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [NS-1:0] irq_req = '0;
	logic [NS-1:0][2:0] irq_level = {NS{3'h7}};
	logic hp_pending = 1'b0;
	logic [NS-1:0] cpu_irq_req;
	logic [NS-1:0] req_ack;
	logic eot_irq;
	logic [31:0] eot_jump_addr;
	logic busy;
	tdte_pkg::tdte_mem_req_t mem_req;
	logic [7:0] mem_rdata;
	int bad_count = 0;
	int cmp_count = 0;
	int eot_n = 0;
	int cyc = 0;

	tdte_engine #(.N_SRC(NS)) dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq_req(irq_req), .irq_level(irq_level), .hp_pending(hp_pending),
		.vector_base(24'h000100), .cpu_irq_req(cpu_irq_req), .req_ack(req_ack),
		.eot_irq(eot_irq), .eot_jump_addr(eot_jump_addr), .busy(busy),
		.mem_req(mem_req), .mem_rdata(mem_rdata));
	tdte_mem_model mem_i (.mclk(mclk), .mem_req(mem_req), .mem_rdata(mem_rdata));

	always #25 mclk = ~mclk;

	always @(posedge mclk)
	begin
		cyc++;
		if (eot_irq === 1'b1)
			eot_n++;
		if (cyc == 20000)
		begin
			bad_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic put16(input logic [23:0] a, input logic [15:0] v);
		mem_i.mem[a] = v[7:0];
		mem_i.mem[a + 24'h1] = v[15:8];
	endtask

	function automatic logic [15:0] get16(input logic [23:0] a);
		return {mem_i.mem[a + 24'h1], mem_i.mem[a]};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk("reg", e, reg_rdata);
		@(posedge mclk);
	endtask

	// The peripheral holds its request until acknowledged, then drops it.
	task automatic req(input int i);
		int n;
		n = 0;
		irq_req[i] <= 1'b1;
		@(posedge mclk);
		while (req_ack[i] !== 1'b1 && n < 40)
		begin
			@(posedge mclk);
			n++;
		end
		irq_req[i] <= 1'b0;
		chk("ack", 1'b1, req_ack[i]);
		// Busy lags the ack, so give it time to rise before polling.
		repeat (2) @(posedge mclk);
		while (busy !== 1'b0 && n < 3000)
		begin
			@(posedge mclk);
			n++;
		end
		chk("idle", 1'b0, busy);
		repeat (2) @(posedge mclk);
	endtask

	task automatic run(input logic [15:0] m, c, a, b, e);
		put16(24'h100, 16'h0200);
		put16(24'h102, 16'h0000);
		put16(24'h200, m);
		put16(24'h202, c);
		put16(24'h204, a);
		put16(24'h206, b);
		put16(24'h208, e);
		req(0);
	endtask

	task automatic s_regs();
		irq_req[0] <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("cpu_irq", 1'b1, cpu_irq_req[0]);
		chk("busy", 1'b0, busy);
		irq_req[0] <= 1'b0;
		rdc(8'h9F, 8'h00);
		wr(8'h9F, 8'h20);
		rdc(8'h9F, 8'h20);
		wr(8'h55, 8'hFF);
		rdc(8'h55, 8'h00);
		rdc(8'hA0, 8'h00);
	endtask

	task automatic s_route();
		int e0;
		e0 = eot_n;
		put16(24'h104, 16'h0200);
		put16(24'h106, 16'h0000);
		put16(24'h200, 16'h0048);
		put16(24'h202, 16'h0000);
		put16(24'h204, 16'h0300);
		put16(24'h206, 16'h0900);
		put16(24'h900, 16'h0000);
		irq_level[1] <= 3'h3;
		irq_req[1] <= 1'b1;
		repeat (4) @(posedge mclk);
		chk("cpu_irq", 1'b1, cpu_irq_req[1]);
		hp_pending <= 1'b1;
		irq_level[1] <= 3'h7;
		repeat (10) @(posedge mclk);
		chk("cpu_irq", 1'b0, cpu_irq_req[1]);
		chk("busy", 1'b0, busy);
		hp_pending <= 1'b0;
		req(1);
		chk("dst", 16'h0000, get16(24'h900));
		chk("count", 16'h0000, get16(24'h202));
		chk("eot", e0, eot_n);
	endtask

	task automatic s_single();
		put16(24'h300, 16'h2211);
		put16(24'h400, 16'h0000);
		run(16'h000C, 16'h0002, 16'h0300, 16'h0400, 16'h0000);
		chk("dst", 16'h0011, get16(24'h400));
		chk("count", 16'h0001, get16(24'h202));
		chk("src", 16'h0301, get16(24'h204));
		chk("dstf", 16'h0401, get16(24'h206));
		req(0);
		chk("dst", 16'h2211, get16(24'h400));
	endtask

	task automatic s_burst();
		int e0;
		e0 = eot_n;
		put16(24'hFFFF, 16'h1234);
		put16(24'h20A, 16'h0012);
		run(16'h0069, 16'h0002, 16'hFFFF, 16'h0500, 16'h5678);
		chk("burst", 32'h12341234, {get16(24'h502), get16(24'h500)});
		chk("count", 16'h0000, get16(24'h202));
		chk("src", 16'hFFFF, get16(24'h204));
		chk("eot", e0 + 1, eot_n);
		chk("jump", 32'h00125678, eot_jump_addr);
	endtask

	task automatic s_imm();
		put16(24'h000, 16'h0000);
		run(16'h002A, 16'h0002, 16'hAB5C, 16'hFFFF, 16'h0000);
		chk("imm", 16'h125C, get16(24'hFFFF));
		chk("wrap", 16'h005C, get16(24'h000));
		chk("dstf", 16'h0001, get16(24'h206));
	endtask

	task automatic s_arith();
		int e0;
		e0 = eot_n;
		put16(24'h310, 16'h0605);
		put16(24'h600, 16'h0000);
		run(16'h012C, 16'h0002, 16'h0300, 16'h0310, 16'h0600);
		chk("sum", 16'h2816, get16(24'h600));
		chk("op", 16'h0312, get16(24'h206));
		chk("dstf", 16'h0602, get16(24'h208));
		// Immediate word plus memory, so the chain and jump pointers sit behind the operand field.
		put16(24'h20A, 16'h0250);
		put16(24'h20C, 16'h0000);
		put16(24'h20E, 16'h4321);
		put16(24'h210, 16'h0087);
		put16(24'h620, 16'h0000);
		run(16'h01CB, 16'h0001, 16'h1111, 16'h0310, 16'h0620);
		chk("isum", 16'h1716, get16(24'h620));
		chk("iop", 16'h0310, get16(24'h206));
		chk("idst", 16'h0622, get16(24'h208));
		chk("icount", 16'h0000, get16(24'h202));
		chk("ivec", 32'h00000250, {get16(24'h102), get16(24'h100)});
		chk("ieot", e0 + 1, eot_n);
		chk("ijump", 32'h00874321, eot_jump_addr);
	endtask

	task automatic s_multi();
		put16(24'h20A, 16'h0701);
		put16(24'h700, 16'h0000);
		run(16'h8020, 16'h0005, 16'h0300, 16'h0700, 16'h0301);
		chk("multi", 16'h2211, get16(24'h700));
		chk("count", 16'h0005, get16(24'h202));
	endtask

	task automatic s_chain();
		put16(24'h20A, 16'h0000);
		put16(24'h800, 16'h0000);
		run(16'h0080, 16'h0001, 16'h0300, 16'h0800, 16'h0240);
		chk("copy", 16'h0011, get16(24'h800));
		chk("vec", 32'h00000240, {get16(24'h102), get16(24'h100)});
	endtask

	initial
	begin
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		s_regs();
		s_route();
		s_single();
		s_burst();
		s_imm();
		s_arith();
		s_multi();
		s_chain();
		stop_test();
	end
endmodule

`default_nettype wire
